// File: verilog/counter_clock_gate_routing.sv
/*
  Clock and gate routing fabric for up to twelve counter channels, with APB
  configuration registers, internal clock dividers and a level interrupt.
  Assumes counter chips and connector pins are asynchronous to pclk.
*/
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
module counter_clock_gate_routing
  import route_pkg::*;
#(
  parameter bit HIGH_CHIPS_FITTED = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] counter_output,
  output logic [11:0] counter_clock,
  output logic [11:0] counter_gate,
  input wire logic [7:0] external_clock_pin,
  input wire logic [7:0] external_gate_pin_in,
  output logic [3:0] external_gate_pin_out,
  output logic [3:0] external_gate_pin_oe,
  output logic [9:0] connector_output,
  output logic inverted_divider_output,
  output logic watchdog_source,
  output logic fast_internal_clock,
  output logic slow_internal_clock,
  output logic irq
);

  // Channel number of independent counter k
  function automatic int chan_of(input int k);
    return (k < 4) ? k : k + 2;
  endfunction

  // Channel whose output is the cascade clock of independent counter k
  function automatic int casc_of(input int k);
    if (k == 0) begin
      return 3;
    end else if (k == 4) begin
      return 9;
    end
    return chan_of(k) - 1;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == CLK_SEL_OFS) || (a == GATE_SEL_OFS) || (a == FREQ_SEL_OFS) ||
      (a == STATUS_OFS) || (a == MASK_OFS) || (a == LEVELS_OFS);
  endfunction

  // Pin synchroniser: counter outputs, clock pins, gate pins
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= '0;
      sync_q <= '0;
    end else begin
      sync_meta <= {external_gate_pin_in, external_clock_pin, counter_output};
      sync_q <= sync_meta;
    end
  end

  logic [11:0] cout_s;
  logic [7:0] eclk_s;
  logic [7:0] egate_s;
  assign cout_s = HIGH_CHIPS_FITTED ? sync_q[11:0] : {6'h00, sync_q[5:0]};
  assign eclk_s = sync_q[19:12];
  assign egate_s = sync_q[27:20];

  // Oscillator half-period tick from a fractional accumulator
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic osc_tick;
  logic next_osc_tick;
  always_comb begin
    next_osc_tick = (acc + ACC_STEP) >= ACC_MOD;
    next_acc = next_osc_tick ? acc + ACC_STEP - ACC_MOD : acc + ACC_STEP;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 8'h00;
      osc_tick <= 1'b0;
    end else begin
      acc <= next_acc;
      osc_tick <= next_osc_tick;
    end
  end

  // Configuration and interrupt registers
  logic [15:0] clk_sel;
  logic [3:0] gate_sel;
  logic [1:0] freq_sel;
  logic [1:0] status;
  logic [1:0] mask;
  logic [15:0] next_clk_sel;
  logic [3:0] next_gate_sel;
  logic [1:0] next_freq_sel;
  logic [1:0] next_status;
  logic [1:0] next_mask;
  logic [31:0] next_prdata;
  logic [1:0] event_set;
  logic wr_en;

  // Internal clocks, all derived from the oscillator ticks
  logic fast_tick;
  logic fixed_wave;
  logic [6:0] slow_div;
  assign slow_div = freq_sel[FREQ_FAST_BIT] ?
    (freq_sel[FREQ_SLOW_BIT] ? DIV_SLOW_HI_OF_HI : DIV_SLOW_LO_OF_HI) :
    (freq_sel[FREQ_SLOW_BIT] ? DIV_SLOW_HI_OF_LO : DIV_SLOW_LO_OF_LO);

  tick_divider #(.DIV_W(7)) fast_div_i (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(osc_tick),
    .div(freq_sel[FREQ_FAST_BIT] ? DIV_FAST_HI : DIV_FAST_LO),
    .tick_out(fast_tick),
    .wave(fast_internal_clock)
  );

  tick_divider #(.DIV_W(7)) slow_div_i (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(fast_tick),
    .div(slow_div),
    .tick_out(),
    .wave(slow_internal_clock)
  );

  tick_divider #(.DIV_W(7)) fixed_div_i (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(osc_tick),
    .div(DIV_FIXED),
    .tick_out(),
    .wave(fixed_wave)
  );

  // Routing of clocks, gates, connector and interrupt sources
  logic [11:0] next_clock;
  logic [11:0] next_gate;
  logic [9:0] next_conn;
  logic [3:0] next_gout;
  logic [3:0] next_goe;
  always_comb begin
    next_clock = '0;
    next_gate = '0;
    next_conn = '0;
    next_gout = '0;
    next_goe = '0;
    for (int k = 0; k < NUM_INDEP; k++) begin
      if (k < 4 || HIGH_CHIPS_FITTED) begin
        case (clk_sel[2*k +: 2])
          CSEL_FAST: next_clock[chan_of(k)] = fast_internal_clock;
          CSEL_SLOW: next_clock[chan_of(k)] = slow_internal_clock;
          CSEL_CASCADE: next_clock[chan_of(k)] = cout_s[casc_of(k)];
          CSEL_EXT: next_clock[chan_of(k)] = eclk_s[k];
          default: next_clock[chan_of(k)] = 1'b0;
        endcase
        next_gate[chan_of(k)] = egate_s[k];
        next_conn[k] = cout_s[chan_of(k)];
      end
    end
    for (int g = 0; g < 4; g++) begin
      if (gate_sel[g]) begin
        next_gate[g] = ~cout_s[5];
        next_gout[g] = ~cout_s[5];
        next_goe[g] = 1'b1;
      end
    end
    // Fixed divider pairs: no selector, gates tied high
    next_clock[4] = fixed_wave;
    next_clock[5] = cout_s[4];
    next_gate[4] = 1'b1;
    next_gate[5] = 1'b1;
    next_conn[8] = cout_s[5];
    if (HIGH_CHIPS_FITTED) begin
      next_clock[10] = fixed_wave;
      next_clock[11] = cout_s[10];
      next_gate[10] = 1'b1;
      next_gate[11] = 1'b1;
      next_conn[9] = cout_s[11];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_clock <= '0;
      counter_gate <= GATE_RST;
      connector_output <= '0;
      external_gate_pin_out <= '0;
      external_gate_pin_oe <= '0;
      inverted_divider_output <= 1'b1;
      watchdog_source <= 1'b0;
    end else begin
      counter_clock <= next_clock;
      counter_gate <= next_gate;
      connector_output <= next_conn;
      external_gate_pin_out <= next_gout;
      external_gate_pin_oe <= next_goe;
      inverted_divider_output <= ~cout_s[5];
      watchdog_source <= cout_s[11];
    end
  end

  // Events: inverted output 6 falls, output 12 rises
  assign event_set[ST_MEAS_END] = inverted_divider_output & cout_s[5];
  assign event_set[ST_WATCHDOG] = ~watchdog_source & cout_s[11];

  // APB slave: zero wait states, error on unmapped access
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign wr_en = psel & penable & pwrite;
  assign irq = |(status & mask);

  always_comb begin
    next_clk_sel = clk_sel;
    next_gate_sel = gate_sel;
    next_freq_sel = freq_sel;
    next_mask = mask;
    next_status = status;
    next_prdata = prdata;
    if (wr_en) begin
      case (paddr)
        CLK_SEL_OFS: next_clk_sel = pwdata[15:0];
        GATE_SEL_OFS: next_gate_sel = pwdata[3:0];
        FREQ_SEL_OFS: next_freq_sel = pwdata[1:0];
        MASK_OFS: next_mask = pwdata[1:0];
        STATUS_OFS: next_status = status & ~pwdata[1:0];
        default: next_status = status;
      endcase
    end
    next_status = next_status | event_set; // Set wins over clear
    if (psel && !penable) begin
      case (paddr)
        CLK_SEL_OFS: next_prdata = {16'h0000, clk_sel};
        GATE_SEL_OFS: next_prdata = {28'h0000000, gate_sel};
        FREQ_SEL_OFS: next_prdata = {30'h00000000, freq_sel};
        STATUS_OFS: next_prdata = {30'h00000000, status};
        MASK_OFS: next_prdata = {30'h00000000, mask};
        LEVELS_OFS: next_prdata = {12'h000, egate_s, cout_s};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel <= CLK_SEL_RST;
      gate_sel <= GATE_SEL_RST;
      freq_sel <= FREQ_SEL_RST;
      status <= '0;
      mask <= MASK_RST;
      prdata <= '0;
    end else begin
      clk_sel <= next_clk_sel;
      gate_sel <= next_gate_sel;
      freq_sel <= next_freq_sel;
      status <= next_status;
      mask <= next_mask;
      prdata <= next_prdata;
    end
  end

  // Check helpers: warm-up after reset and fixed clock half-period
  logic [2:0] warm_cnt;
  logic warm;
  logic fixed_prev;
  logic fixed_seen;
  logic [6:0] fixed_gap;
  assign warm = (warm_cnt == 3'h5);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_cnt <= 3'h0;
      fixed_prev <= 1'b0;
      fixed_seen <= 1'b0;
      fixed_gap <= 7'h00;
    end else begin
      warm_cnt <= warm ? warm_cnt : warm_cnt + 3'h1;
      fixed_prev <= fixed_wave;
      fixed_seen <= fixed_seen | (fixed_wave != fixed_prev);
      fixed_gap <= (fixed_wave != fixed_prev) ? 7'h00 : fixed_gap + 7'h01;
    end
  end

  chk_fixed_gate: assert property (@(posedge pclk) disable iff (!presetn)
    counter_gate[4] && counter_gate[5])
    else $error("Divider counter gate dropped");

  chk_fixed_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (fixed_seen && fixed_wave != fixed_prev) |-> (fixed_gap == 7'h3d || fixed_gap == 7'h3e))
    else $error("Fixed clock half period not 62 or 63 cycles");

  chk_divider_chain: assert property (@(posedge pclk) disable iff (!presetn)
    warm |-> counter_clock[5] == $past(counter_output[4], 3))
    else $error("Counter 6 clock does not follow counter 5 output");

  chk_wrap_cascade: assert property (@(posedge pclk) disable iff (!presetn)
    (warm && $past(clk_sel[1:0]) == CSEL_CASCADE) |-> counter_clock[0] == $past(counter_output[3], 3))
    else $error("Counter 1 cascade clock is not counter 4 output");

  chk_lower_cascade: assert property (@(posedge pclk) disable iff (!presetn)
    (warm && $past(clk_sel[3:2]) == CSEL_CASCADE) |-> counter_clock[1] == $past(counter_output[0], 3))
    else $error("Counter 2 cascade clock is not counter 1 output");

  chk_gate_cascade: assert property (@(posedge pclk) disable iff (!presetn)
    (warm && $past(gate_sel[0])) |-> counter_gate[0] == !$past(counter_output[5], 3))
    else $error("Cascaded gate is not inverted output 6");

  chk_gate_drive: assert property (@(posedge pclk) disable iff (!presetn)
    $past(gate_sel[0]) |-> external_gate_pin_oe[0] && external_gate_pin_out[0] == counter_gate[0])
    else $error("Gate pin not driven with cascaded gate");

  chk_gate_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (warm && !$past(gate_sel[0])) |-> !external_gate_pin_oe[0] && counter_gate[0] == $past(external_gate_pin_in[0], 3))
    else $error("External gate pin not routed to gate 1");

  chk_connector: assert property (@(posedge pclk) disable iff (!presetn)
    warm |-> connector_output[8] == $past(counter_output[5], 3))
    else $error("Output 6 missing at connector");

  chk_meas_end: assert property (@(posedge pclk) disable iff (!presetn)
    (warm && $rose(cout_s[5])) |=> status[ST_MEAS_END] && (!mask[ST_MEAS_END] || irq))
    else $error("Measurement end not flagged");

  cov_cascade_gate: cover property (@(posedge pclk) disable iff (!presetn)
    external_gate_pin_oe[0] ##1 $fell(counter_gate[0]));
  cov_meas_irq: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq) && status[ST_MEAS_END]);
  cov_watchdog: cover property (@(posedge pclk) disable iff (!presetn)
    status[ST_WATCHDOG] && mask[ST_WATCHDOG]);
  cov_cascade_clk: cover property (@(posedge pclk) disable iff (!presetn)
    clk_sel[1:0] == CSEL_CASCADE && $rose(counter_clock[0]));

endmodule

// File: verilog/route_pkg.sv
/*
  Constants, encodings and register map of the counter clock and gate routing fabric.
  Assumes a single 125 MHz bus clock, counter chips and connector pins outside.
*/
// Summary of operation
// - 5, 11 run 1 MHz, feed 6, 12
// - Divider counter gates held permanently high
// - Cascaded pairs divide down to very low rates
// - Four-way clock choice per independent counter
// - Cascade clock is next-lower counter output
// - Counter 1 from 4, counter 7 from 10
// - Divider counter clocks fixed, no selector
// - Reset: 1-4 fast clock, 7-10 external pin
// - Independent gates default high when undriven
// - Gates 1-4 choose pin or inverted output 6
// - Cascaded gate drives the gate pin out
// - Gate choice resets to external pin
// - Ten counter outputs reach the connector
// - Outputs 6 and 12 feed interrupt logic
// - Internal clocks divided from 10 MHz oscillator
// - Slow clock is 1 MHz or 100 kHz
// - Falling inverted output 6 ends measurement
package route_pkg;

  // Clock rates
  localparam int PCLK_HZ = 125_000_000;
  localparam int OSC_HZ = 10_000_000;
  localparam int FAST_HI_HZ = 10_000_000;
  localparam int FAST_LO_HZ = 2_000_000;
  localparam int SLOW_HI_HZ = 1_000_000;
  localparam int SLOW_LO_HZ = 100_000;
  localparam int FIXED_HZ = 1_000_000;

  // Oscillator half-period tick accumulator, steps in units of 1 MHz
  localparam logic [7:0] ACC_MOD = 8'(PCLK_HZ / 1_000_000);
  localparam logic [7:0] ACC_STEP = 8'(2 * OSC_HZ / 1_000_000);

  // Divider ratios, counted in half periods of the source clock
  localparam logic [6:0] DIV_FAST_HI = 7'(OSC_HZ / FAST_HI_HZ);
  localparam logic [6:0] DIV_FAST_LO = 7'(OSC_HZ / FAST_LO_HZ);
  localparam logic [6:0] DIV_SLOW_HI_OF_HI = 7'(FAST_HI_HZ / SLOW_HI_HZ);
  localparam logic [6:0] DIV_SLOW_LO_OF_HI = 7'(FAST_HI_HZ / SLOW_LO_HZ);
  localparam logic [6:0] DIV_SLOW_HI_OF_LO = 7'(FAST_LO_HZ / SLOW_HI_HZ);
  localparam logic [6:0] DIV_SLOW_LO_OF_LO = 7'(FAST_LO_HZ / SLOW_LO_HZ);
  localparam logic [6:0] DIV_FIXED = 7'(OSC_HZ / FIXED_HZ);

  // Register offsets
  localparam logic [7:0] CLK_SEL_OFS = 8'h00;
  localparam logic [7:0] GATE_SEL_OFS = 8'h04;
  localparam logic [7:0] FREQ_SEL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam logic [7:0] LEVELS_OFS = 8'h14;

  // Reset values
  localparam logic [15:0] CLK_SEL_RST = 16'hff00;
  localparam logic [3:0] GATE_SEL_RST = 4'h0;
  localparam logic [1:0] FREQ_SEL_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [11:0] GATE_RST = 12'hfff;

  // Field positions
  localparam int FREQ_FAST_BIT = 0;
  localparam int FREQ_SLOW_BIT = 1;
  localparam int ST_MEAS_END = 0;
  localparam int ST_WATCHDOG = 1;
  localparam int NUM_INDEP = 8;
  localparam int SYNC_W = 28;

  // Clock source encoding per independent counter
  typedef enum logic [1:0] {
    CSEL_FAST = 2'h0,
    CSEL_SLOW = 2'h1,
    CSEL_CASCADE = 2'h2,
    CSEL_EXT = 2'h3
  } clk_sel_e;

endpackage

// File: verilog/tick_divider.sv
/*
  Enable-pulse divider: counts input ticks and emits a square wave and a tick.
  Assumes tick_in is a one-cycle enable on pclk and div is at least one.
*/
`timescale 1ns/100ps
module tick_divider
  import route_pkg::*;
#(
  parameter int DIV_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic [DIV_W-1:0] div,
  output logic tick_out,
  output logic wave
);

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic next_tick;
  logic next_wave;

  // Toggle the wave every div input ticks; a shrunk div wraps at once
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    next_wave = wave;
    if (tick_in) begin
      if (cnt >= div - DIV_W'(1)) begin
        next_cnt = '0;
        next_tick = 1'b1;
        next_wave = ~wave;
      end else begin
        next_cnt = cnt + DIV_W'(1);
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      tick_out <= 1'b0;
      wave <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick_out <= next_tick;
      wave <= next_wave;
    end
  end

  chk_tick_toggles: assert property (@(posedge pclk) disable iff (!presetn)
    tick_out |-> (wave != $past(wave)))
    else $error("Divider tick without wave toggle");

endmodule

// File: bench/chip_side_model.sv
/*
  Behavioural counter chips and connector gate pins facing the routing fabric.
  Assumes the bench sets output levels of programmed counters and pin drive.
*/
`timescale 1ns/100ps
module chip_side_model (
  input wire logic [11:0] counter_clock,
  input wire logic [11:0] counter_gate,
  input wire logic [11:0] cout_drv,
  input wire logic [7:0] gate_drv,
  input wire logic [7:0] gate_drv_en,
  input wire logic [3:0] external_gate_pin_out,
  input wire logic [3:0] external_gate_pin_oe,
  output logic [11:0] counter_output,
  output logic [7:0] external_gate_pin_in
);
  logic div5 = 1'b0;
  logic div11 = 1'b0;

  // First stage of each divider pair toggles per clock while enabled
  always @(posedge counter_clock[4]) if (counter_gate[4]) div5 <= ~div5;
  always @(posedge counter_clock[10]) if (counter_gate[10]) div11 <= ~div11;

  // Other counters show the levels the bench programs
  always_comb begin
    counter_output = cout_drv;
    counter_output[4] = div5;
    counter_output[10] = div11;
  end

  // Gate pins: fabric drive wins, model backs off, pull-up otherwise
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      if ((k < 4) && external_gate_pin_oe[k % 4])
        external_gate_pin_in[k] = external_gate_pin_out[k % 4];
      else if (gate_drv_en[k])
        external_gate_pin_in[k] = gate_drv[k];
      else
        external_gate_pin_in[k] = 1'b1;
    end
  end
endmodule

// File: bench/counter_clock_gate_routing_bench.sv
/*
  Self-checking bench for the counter clock and gate routing fabric.
  Assumes the chip side model; the bench is the APB master and the connector.
*/
`timescale 1ns/100ps
module counter_clock_gate_routing_bench;
  import route_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, external_clock_pin = 8'h00, gate_drv = 8'h00, gate_drv_en = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, inverted_divider_output, watchdog_source, irq;
  logic fast_internal_clock, slow_internal_clock;
  logic [11:0] cout_drv = 12'h000, counter_output, counter_clock, counter_gate;
  logic [7:0] external_gate_pin_in;
  logic [3:0] external_gate_pin_out, external_gate_pin_oe;
  logic [9:0] connector_output;
  logic [11:0] lo_clock, lo_gate;
  logic [9:0] lo_conn;
  int error_cnt = 0;
  int num_checks = 0;
  // Counter bit of each independent channel and of its cascade source
  int cnt_bit [8] = '{0, 1, 2, 3, 6, 7, 8, 9};
  int casc_bit [8] = '{3, 0, 1, 2, 9, 6, 7, 8};

  counter_clock_gate_routing dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .counter_output, .counter_clock, .counter_gate, .external_clock_pin,
    .external_gate_pin_in, .external_gate_pin_out, .external_gate_pin_oe,
    .connector_output, .inverted_divider_output, .watchdog_source,
    .fast_internal_clock, .slow_internal_clock, .irq
  );

  // Second fabric with the upper chips left out
  counter_clock_gate_routing #(.HIGH_CHIPS_FITTED(1'b0)) dut_lo (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(),
    .pslverr(), .counter_output, .counter_clock(lo_clock), .counter_gate(lo_gate),
    .external_clock_pin, .external_gate_pin_in, .external_gate_pin_out(),
    .external_gate_pin_oe(), .connector_output(lo_conn), .inverted_divider_output(),
    .watchdog_source(), .fast_internal_clock(), .slow_internal_clock(), .irq()
  );

  chip_side_model chips (
    .counter_clock, .counter_gate, .cout_drv, .gate_drv, .gate_drv_en,
    .external_gate_pin_out, .external_gate_pin_oe, .counter_output, .external_gate_pin_in
  );

  // 125 MHz clock
  always #4 pclk = ~pclk;

  task automatic close_out;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rate(input string what, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // One APB transfer; data and error are taken at the completing rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                        input logic err_exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
    chk({what, " slverr"}, {31'h0, err_exp}, {31'h0, e});
  endtask

  // Set chip and pin levels, then wait past the synchroniser and route flops
  task automatic drive(input logic [11:0] c, input logic [7:0] e, input logic [7:0] ge);
    @(posedge pclk);
    cout_drv <= c;
    external_clock_pin <= e;
    gate_drv <= 8'h00;
    gate_drv_en <= ge;
    repeat (5) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Rising edges of one counter clock over n cycles
  task automatic rate(input int b, input int n, output int c);
    logic p;
    c = 0;
    @(negedge pclk);
    p = counter_clock[b];
    repeat (n) begin
      @(negedge pclk);
      if (counter_clock[b] === 1'b1 && p === 1'b0)
        c++;
      p = counter_clock[b];
    end
  endtask

  task automatic t_reset;
    rd_chk("clk_sel", CLK_SEL_OFS, 32'h0000ff00, 1'b0);
    rd_chk("gate_sel", GATE_SEL_OFS, 32'h0, 1'b0);
    rd_chk("freq_sel", FREQ_SEL_OFS, 32'h0, 1'b0);
    rd_chk("status", STATUS_OFS, 32'h0, 1'b0);
    rd_chk("mask", MASK_OFS, 32'h0, 1'b0);
    rd_chk("unmapped", 8'h18, 32'h0, 1'b1);
    chk("divider gates", 32'hc30, {20'h0, counter_gate & 12'hc30});
    chk("inverted out", 32'h1, {31'h0, inverted_divider_output});
  endtask

  task automatic t_default;
    int n;
    drive(12'h000, 8'ha0, 8'h00);
    chk("ext clocks", 32'ha, {28'h0, counter_clock[9:6]});
    drive(12'h000, 8'h50, 8'h00);
    chk("ext clocks", 32'h5, {28'h0, counter_clock[9:6]});
    rate(0, 1000, n);
    chk_rate("fast 2 MHz", 15, 17, n);
  endtask

  task automatic t_clk_sel;
    int n;
    logic [11:0] pat;
    wr(FREQ_SEL_OFS, 32'h3);
    wr(CLK_SEL_OFS, 32'h0000);
    rate(2, 500, n);
    chk_rate("fast 10 MHz", 39, 41, n);
    wr(CLK_SEL_OFS, 32'h5555);
    rate(7, 1000, n);
    chk_rate("slow 1 MHz", 7, 9, n);
    wr(CLK_SEL_OFS, 32'haaaa);
    for (int i = 0; i < 2; i++) begin
      pat = i ? 12'h2c5 : 12'hd3a;
      drive(pat, 8'h00, 8'h00);
      for (int k = 0; k < 8; k++)
        chk("cascade clock", {31'h0, pat[casc_bit[k]]}, {31'h0, counter_clock[cnt_bit[k]]});
    end
    wr(CLK_SEL_OFS, 32'hffff);
    drive(12'h000, 8'h3c, 8'h00);
    chk("pin clocks", 32'h3c, {24'h0, counter_clock[9:6], counter_clock[3:0]});
    drive(12'h000, 8'hc3, 8'h00);
    chk("pin clocks", 32'hc3, {24'h0, counter_clock[9:6], counter_clock[3:0]});
  endtask

  task automatic t_fixed;
    int n;
    rate(4, 1250, n);
    chk_rate("counter 5 clock", 9, 11, n);
    rate(10, 1250, n);
    chk_rate("counter 11 clock", 9, 11, n);
    rate(5, 1250, n);
    chk_rate("counter 6 clock", 4, 6, n);
    rate(11, 1250, n);
    chk_rate("counter 12 clock", 4, 6, n);
    wr(CLK_SEL_OFS, 32'hff00);
  endtask

  task automatic t_gate;
    drive(12'h000, 8'h00, 8'hff);
    chk("gates driven low", 32'h0, {20'h0, counter_gate & 12'h3cf});
    chk("gate pin oe", 32'h0, {28'h0, external_gate_pin_oe});
    drive(12'h000, 8'h00, 8'h00);
    chk("gates pulled up", 32'hfff, {20'h0, counter_gate});
    wr(GATE_SEL_OFS, 32'h5);
    drive(12'h000, 8'h00, 8'hff);
    chk("gate mix", 32'h005, {20'h0, counter_gate & 12'h3cf});
    chk("gate pin oe", 32'h5, {28'h0, external_gate_pin_oe});
    chk("gate pin out", 32'h5, {28'h0, external_gate_pin_out & 4'h5});
    drive(12'h020, 8'h00, 8'hff);
    chk("inverted out", 32'h0, {31'h0, inverted_divider_output});
    chk("gates closed", 32'h0, {20'h0, counter_gate & 12'h3cf});
    chk("gate pin out", 32'h0, {28'h0, external_gate_pin_out & 4'h5});
    wr(GATE_SEL_OFS, 32'h0);
    drive(12'h000, 8'h00, 8'h00);
    chk("gate pin oe", 32'h0, {28'h0, external_gate_pin_oe});
  endtask

  task automatic t_conn;
    logic [11:0] pat;
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 2; i++) begin
      pat = i ? 12'h65a : 12'h9a5;
      drive(pat, 8'h00, 8'h00);
      chk("connector", {22'h0, pat[11], pat[5], pat[9:6], pat[3:0]}, {22'h0, connector_output});
      chk("absent connector", {22'h0, 1'b0, pat[5], 4'h0, pat[3:0]}, {22'h0, lo_conn});
      chk("absent gates", 32'h03f, {20'h0, lo_gate});
      chk("absent clocks", 32'h0, {26'h0, lo_clock[11:6]});
      apb(1'b0, LEVELS_OFS, 32'h0, r, e);
      chk("levels", {12'h0, 8'hff, pat} & 32'hffbef, r & 32'hffbef);
    end
  endtask

  task automatic t_irq;
    drive(12'h000, 8'h00, 8'h00);
    wr(STATUS_OFS, 32'h3);
    wr(MASK_OFS, 32'h1);
    rd_chk("status clear", STATUS_OFS, 32'h0, 1'b0);
    drive(12'h020, 8'h00, 8'h00);
    rd_chk("status c6", STATUS_OFS, 32'h1, 1'b0);
    chk("irq c6", 32'h1, {31'h0, irq});
    wr(STATUS_OFS, 32'h1);
    rd_chk("status w1c", STATUS_OFS, 32'h0, 1'b0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    drive(12'h820, 8'h00, 8'h00);
    rd_chk("status c12", STATUS_OFS, 32'h2, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("watchdog src", 32'h1, {31'h0, watchdog_source});
    wr(MASK_OFS, 32'h3);
    @(negedge pclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(STATUS_OFS, 32'h2);
    @(negedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_default;
    t_clk_sel;
    t_fixed;
    t_gate;
    t_conn;
    t_irq;
    close_out;
  end

  // Watchdog against a hang
  initial begin
    repeat (50000) @(posedge pclk);
    error_cnt++;
    $display("ERROR watchdog expected done seen timeout");
    close_out;
  end
endmodule
